// File: rtl/utx_regs.svh
// Constants of the serial transmit path: counts, codes and reset levels
`ifndef UTX_REGS_SVH
`define UTX_REGS_SVH

// -----------------------------------------------------------------------
// Bit-rate prescaling
// -----------------------------------------------------------------------
`define UTX_PRESCALE_NORMAL 4'hF
`define UTX_PRESCALE_DOUBLE 4'h7
`define UTX_DIVISOR_WIDTH 12
`define UTX_COUNT_ZERO 12'h000

// -----------------------------------------------------------------------
// Frame format codes
// -----------------------------------------------------------------------
`define UTX_SIZE_NINE 3'h7
`define UTX_NINE_BITS 4'h9
`define UTX_DATA_BITS_MIN 4'h5
`define UTX_CHAR_WIDTH 9
`define UTX_FULL_MASK 9'h1FF

// -----------------------------------------------------------------------
// Line levels and reset values
// -----------------------------------------------------------------------
`define UTX_LINE_IDLE 1'b1
`define UTX_START_LEVEL 1'b0
`define UTX_STOP_LEVEL 1'b1
`define UTX_SHIFT_RESET 9'h000
`define UTX_BITCNT_RESET 4'h0

`endif

// File: rtl/utx_pkg.sv
// Types shared by the serial transmit path
package utx_pkg;

	// Frame sequencer states
	typedef enum logic [2:0] {
		UTX_IDLE = 3'b000,
		UTX_START = 3'b001,
		UTX_DATA = 3'b010,
		UTX_PARITY = 3'b011,
		UTX_STOP1 = 3'b100,
		UTX_STOP2 = 3'b101
	} utx_state_t;

endpackage

// File: rtl/utx_baud_gen.sv
// Bit-rate down-counter with reload and zero tick
`timescale 1ns/1ps
`include "utx_regs.svh"

module utx_baud_gen (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [11:0] rateDivisor,
	input wire logic divisorLowWrite,
	output logic baudTick
);

	logic [11:0] count_r;
	logic [11:0] count_nxt;
	logic tick_r;
	wire atZero = (count_r == `UTX_COUNT_ZERO);
	wire reload = atZero | divisorLowWrite;

	// Reload at zero or on low divisor write
	assign count_nxt = reload ? rateDivisor : count_r - 12'h001; // [R25]
	assign baudTick = tick_r;

	// Counter and registered tick
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			count_r <= `UTX_COUNT_ZERO;
			tick_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			tick_r <= atZero; // [R25]
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_tick_at_zero: assert property (atZero |=> baudTick) // [R25]
		else $error("tick missing after counter zero");
	a_reload_value: assert property (reload |=> count_r == $past(rateDivisor)) // [R25]
		else $error("divisor not reloaded");

endmodule

// File: rtl/utx_buf2.sv
// Two-entry valid/ready buffer in front of the shift register
`timescale 1ns/1ps

module utx_buf2 #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);

	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = DEPTH[AW:0];

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wrPtr_r;
	logic [AW-1:0] rdPtr_r;
	logic [AW:0] count_r;
	wire push = inValid & inReady;
	wire pop = outValid & outReady;

	// Handshake and read selection
	assign inReady = (count_r != FULL);
	assign outValid = (count_r != '0);
	assign outData = mem_r[rdPtr_r];

	// Entry storage, one writer per entry
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		always_ff @(posedge sys_clk) begin
			if (push && wrPtr_r == AW'(i)) begin
				mem_r[i] <= inData;
			end
		end
	end

	// Pointers and occupancy
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			wrPtr_r <= push ? wrPtr_r + AW'(1) : wrPtr_r;
			rdPtr_r <= pop ? rdPtr_r + AW'(1) : rdPtr_r;
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_count_track: assert property (push && !pop |=> count_r == $past(count_r) + 1'b1) // [R17]
		else $error("occupancy not raised on push");
	a_full_stall: assert property (count_r == FULL |-> !inReady) // [R9] [R14]
		else $error("ready while buffer full");

endmodule

// File: rtl/utx_transmitter.sv
// Serial transmit path: buffer, frame shifter, flags, clock selection
//
// Functional notes
// (R1) Parity is XOR of all data bits
// (R2) Odd parity inverts the XOR result
// (R3) Parity bit sits between data and stop
// (R4) Software sets rate and format before enabling
// (R5) Software changes format only while idle
// (R6) Software clears complete flag before each write
// (R7) Enable takes over the transmit pin
// (R8) Synchronous mode drives and uses serial clock
// (R9) Data write loads buffer, starting transmission
// (R10) Shifter loads when idle or after stop
// (R11) Frame sent at divisor, double-speed or clock
// (R12) Unused upper bits of short characters dropped
// (R13) Ninth bit set before writing low byte
// (R14) Empty flag high exactly while buffer empty
// (R15) Software writes zero to empty flag position
// (R16) Empty interrupt requested while flag set
// (R17) Data write clears the empty flag
// (R18) Empty handler writes data or disables interrupt
// (R19) Complete flag set when frame and buffer done
// (R20) Complete flag cleared by service or write-one
// (R21) Complete interrupt requested when flag set
// (R22) Disable waits for pending data, then releases
// (R23) Start low, data LSB first, parity, stops high
// (R24) Parity only when parity enable set
// (R25) Rate counter reloads at zero, ticks at zero
// (R26) Line idles high between frames
`timescale 1ns/1ps
`include "utx_regs.svh"

module utx_transmitter (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic txEnableBit,
	input wire logic [2:0] charSizeCode,
	input wire logic parityEnableBit,
	input wire logic parityOdd,
	input wire logic twoStopBits,
	input wire logic doubleSpeedBit,
	input wire logic syncMode,
	input wire logic syncMaster,
	input wire logic clockPolarity,
	input wire logic [11:0] rateDivisor,
	input wire logic rateDivisorLowWrite,
	input wire logic dataWrite,
	input wire logic [7:0] dataWriteByte,
	input wire logic txNinthBit,
	output logic dataWriteReady,
	output logic bufferEmptyFlag,
	output logic txCompleteFlag,
	input wire logic txCompleteClear,
	input wire logic txCompleteIrqAck,
	input wire logic bufferEmptyIrqEnable,
	input wire logic txCompleteIrqEnable,
	input wire logic globalIrqEnable,
	output logic bufferEmptyIrq,
	output logic txCompleteIrq,
	output logic txdOut,
	output logic txdOe,
	input wire logic serialClockIn,
	output logic serialClockOut,
	output logic serialClockOe
);

	// -------------------------------------------------------------------
	// Declarations
	// -------------------------------------------------------------------
	utx_pkg::utx_state_t state_r;
	utx_pkg::utx_state_t state_nxt;
	logic [8:0] shift_r;
	logic [8:0] shift_nxt;
	logic [3:0] bitCnt_r;
	logic [3:0] bitCnt_nxt;
	logic txd_r;
	logic txd_nxt;
	logic parity_r;
	logic parity_nxt;
	logic active_r;
	logic txc_r;
	logic [3:0] pre_r;
	logic clkPhase_r;
	logic sck1_r;
	logic sck2_r;
	logic sck3_r;
	logic sckLevel_r;
	logic baudTick;
	logic bufValid;
	logic [8:0] bufData;

	// -------------------------------------------------------------------
	// Character formatting on write
	// -------------------------------------------------------------------
	wire sizeNine = (charSizeCode == `UTX_SIZE_NINE);
	wire [3:0] dataBits = sizeNine ? `UTX_NINE_BITS :
		`UTX_DATA_BITS_MIN + {2'b00, charSizeCode[1:0]};
	wire [8:0] charMask = ~(`UTX_FULL_MASK << dataBits);
	// Ninth bit taken from control at write time
	wire [8:0] writeWord = {txNinthBit, dataWriteByte} & charMask; // [R12] [R13]

	// -------------------------------------------------------------------
	// Transmit buffer and rate generator
	// -------------------------------------------------------------------
	wire loadNow;

	// Data write fills the buffer
	utx_buf2 #(
		.WIDTH(`UTX_CHAR_WIDTH),
		.DEPTH(2)
	) u_buf (
		.sys_clk(sys_clk),
		.rst(rst),
		.inValid(dataWrite), // [R9]
		.inReady(dataWriteReady),
		.inData(writeWord),
		.outValid(bufValid),
		.outReady(loadNow),
		.outData(bufData)
	);

	utx_baud_gen u_baud (
		.sys_clk(sys_clk),
		.rst(rst),
		.rateDivisor(rateDivisor),
		.divisorLowWrite(rateDivisorLowWrite),
		.baudTick(baudTick)
	);

	// -------------------------------------------------------------------
	// Bit clock selection
	// -------------------------------------------------------------------
	wire [3:0] preLimit = doubleSpeedBit ? `UTX_PRESCALE_DOUBLE :
		`UTX_PRESCALE_NORMAL;
	wire sckAgree = (sck2_r == sck3_r);
	wire sckRise = sckAgree & sck3_r & !sckLevel_r;
	wire sckFall = sckAgree & !sck3_r & sckLevel_r;
	wire asyncTick = !syncMode & baudTick & (pre_r == preLimit);
	wire masterTick = syncMode & syncMaster & baudTick & !clkPhase_r;
	wire slaveTick = syncMode & !syncMaster &
		(clockPolarity ? sckFall : sckRise);
	// One strobe per bit period in every mode
	wire bitTick = asyncTick | masterTick | slaveTick; // [R11]

	// Prescaler and master clock phase
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pre_r <= 4'h0;
			clkPhase_r <= 1'b0;
		end else begin
			pre_r <= !baudTick ? pre_r : (asyncTick ? 4'h0 : pre_r + 4'h1);
			clkPhase_r <= clkPhase_r ^ (baudTick & syncMode & active_r);
		end
	end

	// External clock: three stages, change once second and third agree
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sck1_r <= 1'b0;
			sck2_r <= 1'b0;
			sck3_r <= 1'b0;
			sckLevel_r <= 1'b0;
		end else begin
			sck1_r <= serialClockIn;
			sck2_r <= sck1_r;
			sck3_r <= sck2_r;
			sckLevel_r <= sckAgree ? sck3_r : sckLevel_r;
		end
	end

	// -------------------------------------------------------------------
	// Frame sequencer
	// -------------------------------------------------------------------
	wire inIdle = (state_r == utx_pkg::UTX_IDLE);
	wire frameEnd = bitTick & ((state_r == utx_pkg::UTX_STOP2) |
		((state_r == utx_pkg::UTX_STOP1) & !twoStopBits));
	// Take next word when idle or right after last stop
	assign loadNow = active_r & bitTick & bufValid & (inIdle | frameEnd); // [R10]
	wire dataParity = ^bufData; // [R1]

	// Next-state and line value
	always_comb begin
		state_nxt = state_r;
		shift_nxt = shift_r;
		bitCnt_nxt = bitCnt_r;
		txd_nxt = txd_r;
		parity_nxt = parity_r;
		if (loadNow) begin
			state_nxt = utx_pkg::UTX_START;
			shift_nxt = bufData;
			bitCnt_nxt = dataBits - 4'h1;
			parity_nxt = dataParity ^ parityOdd; // [R2]
			txd_nxt = `UTX_START_LEVEL; // [R23]
		end else if (bitTick) begin
			case (state_r)
				utx_pkg::UTX_START: begin
					state_nxt = utx_pkg::UTX_DATA;
					txd_nxt = shift_r[0]; // [R23]
					shift_nxt = shift_r >> 1;
				end
				utx_pkg::UTX_DATA: begin
					if (bitCnt_r != 4'h0) begin
						bitCnt_nxt = bitCnt_r - 4'h1;
						txd_nxt = shift_r[0];
						shift_nxt = shift_r >> 1;
					end else if (parityEnableBit) begin
						state_nxt = utx_pkg::UTX_PARITY; // [R24]
						txd_nxt = parity_r; // [R3]
					end else begin
						state_nxt = utx_pkg::UTX_STOP1;
						txd_nxt = `UTX_STOP_LEVEL;
					end
				end
				utx_pkg::UTX_PARITY: begin
					state_nxt = utx_pkg::UTX_STOP1;
					txd_nxt = `UTX_STOP_LEVEL; // [R23]
				end
				utx_pkg::UTX_STOP1: begin
					state_nxt = twoStopBits ? utx_pkg::UTX_STOP2 :
						utx_pkg::UTX_IDLE;
				end
				default: begin
					state_nxt = utx_pkg::UTX_IDLE;
					txd_nxt = `UTX_LINE_IDLE; // [R26]
				end
			endcase
		end
	end

	// Sequencer registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_r <= utx_pkg::UTX_IDLE;
			shift_r <= `UTX_SHIFT_RESET;
			bitCnt_r <= `UTX_BITCNT_RESET;
			txd_r <= `UTX_LINE_IDLE;
			parity_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			shift_r <= shift_nxt;
			bitCnt_r <= bitCnt_nxt;
			txd_r <= txd_nxt;
			parity_r <= parity_nxt;
		end
	end

	// -------------------------------------------------------------------
	// Enable, flags and requests
	// -------------------------------------------------------------------
	wire drained = inIdle & !bufValid;
	wire txcSet = frameEnd & !bufValid; // [R19]
	wire txcClear = txCompleteClear | txCompleteIrqAck;

	// Enable holds until pending data drains; set wins over clear
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			active_r <= 1'b0;
			txc_r <= 1'b0;
		end else begin
			active_r <= txEnableBit | (active_r & !drained); // [R22]
			txc_r <= txcSet | (txc_r & !txcClear); // [R20]
		end
	end

	// Status, requests and pin control
	assign bufferEmptyFlag = !bufValid; // [R14] [R17]
	assign txCompleteFlag = txc_r;
	assign bufferEmptyIrq = !bufValid & bufferEmptyIrqEnable &
		globalIrqEnable; // [R16]
	assign txCompleteIrq = txc_r & txCompleteIrqEnable &
		globalIrqEnable; // [R21]
	assign txdOut = txd_r;
	assign txdOe = active_r; // [R7]
	assign serialClockOe = active_r & syncMode & syncMaster; // [R8]
	assign serialClockOut = clkPhase_r ^ clockPolarity; // [R8]

	// -------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence sLastData;
		state_r == utx_pkg::UTX_DATA && bitCnt_r == 4'h0 && bitTick &&
			!loadNow;
	endsequence
	sequence sParityOut;
		state_r == utx_pkg::UTX_PARITY && txd_r == parity_r;
	endsequence

	a_parity_place: assert property ((sLastData and parityEnableBit) |=> sParityOut) // [R3]
		else $error("parity bit not after last data bit");
	a_parity_skip: assert property ((sLastData and !parityEnableBit) |=> state_r == utx_pkg::UTX_STOP1 && txd_r) // [R24]
		else $error("parity sent while disabled");
	a_parity_calc: assert property (loadNow |=> parity_r == ((^$past(bufData)) ^ $past(parityOdd))) // [R1] [R2]
		else $error("parity value wrong");
	a_start_low: assert property (loadNow |=> state_r == utx_pkg::UTX_START && !txd_r) // [R23]
		else $error("frame did not open with low start bit");
	a_idle_high: assert property (inIdle |-> txd_r) // [R26]
		else $error("line not high while idle");
	a_back_to_back: assert property (frameEnd && bufValid && active_r |=> state_r == utx_pkg::UTX_START) // [R10]
		else $error("pending word not loaded after stop");
	a_empty_clear: assert property (dataWrite && dataWriteReady |=> !bufferEmptyFlag) // [R17]
		else $error("empty flag not cleared by write");
	a_txc_set: assert property (txcSet |=> txCompleteFlag ##0 (txCompleteIrq == (txCompleteIrqEnable && globalIrqEnable))) // [R19]
		else $error("complete flag not set at frame end");
	a_txc_clear: assert property (txc_r && txcClear && !txcSet |=> !txCompleteFlag) // [R20]
		else $error("complete flag not cleared");
	a_disable_wait: assert property (active_r && !txEnableBit && !drained |=> txdOe) // [R22]
		else $error("pin released before data drained");

endmodule

// File: verif/utx_line_rx.sv
// Remote receiver model that decodes frames seen on the transmit line
`timescale 1ns/1ps

module utx_line_rx (
	input wire logic sys_clk,
	input wire logic lineIn,
	input wire logic serialClockIn,
	input wire logic syncMode,
	input wire logic parityEnableBit,
	input wire logic [3:0] dataBits,
	input wire logic [15:0] bitCycles,
	output logic [8:0] rxWord,
	output logic rxParity,
	output logic rxStart,
	output logic rxStop,
	output int frameCnt
);
	// One bit later: next serial clock rise, or one rate period
	task automatic next_bit(output logic b);
		if (syncMode) begin
			@(posedge serialClockIn);
		end else begin
			repeat (bitCycles) @(posedge sys_clk);
		end
		b = lineIn;
	endtask

	// Start, data LSB first, optional parity, stop
	initial begin
		frameCnt = 0;
		forever begin
			@(negedge lineIn);
			if (syncMode) begin
				@(posedge serialClockIn);
			end else begin
				repeat (bitCycles / 2) @(posedge sys_clk);
			end
			rxStart = lineIn;
			rxWord = 9'h000;
			rxParity = 1'b0;
			for (int i = 0; i < dataBits; i++) next_bit(rxWord[i]);
			if (parityEnableBit) next_bit(rxParity);
			next_bit(rxStop);
			frameCnt++;
		end
	end
endmodule

// File: verif/tb_utx_transmitter.sv
// Self-checking bench of the serial transmit path
`timescale 1ns/1ps

module tb_utx_transmitter;
	logic sys_clk = 1'b0, rst = 1'b1, txEnableBit = 1'b0;
	logic [2:0] charSizeCode = 3'h3;
	logic parityEnableBit = 1'b0, parityOdd = 1'b0, twoStopBits = 1'b0;
	logic doubleSpeedBit = 1'b0, syncMode = 1'b0, syncMaster = 1'b0;
	logic clockPolarity = 1'b0, rateDivisorLowWrite = 1'b0;
	logic [11:0] rateDivisor = 12'h000;
	logic dataWrite = 1'b0, txNinthBit = 1'b0, txCompleteClear = 1'b0;
	logic [7:0] dataWriteByte = 8'h00;
	logic txCompleteIrqAck = 1'b0, bufferEmptyIrqEnable = 1'b0;
	logic txCompleteIrqEnable = 1'b0, globalIrqEnable = 1'b0;
	logic serialClockIn = 1'b0;
	logic dataWriteReady, bufferEmptyFlag, txCompleteFlag, bufferEmptyIrq;
	logic txCompleteIrq, txdOut, txdOe, serialClockOut, serialClockOe;
	logic rxParity, rxStart, rxStop;
	logic [8:0] rxWord;
	logic [3:0] nBits = 4'h8;
	logic [15:0] bitCycles = 16'h0010;
	logic [2:0] sizes[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
	int frameCnt, checks = 0, error_cnt = 0, done = 0, w, k, n;
	int expQ[$];
	wire logic line;
	wire logic rxClk;

	// Released line is pulled high
	assign line = txdOe ? txdOut : 1'b1;
	// Master: receiver samples on the edge opposite the data change; slave: on the same input clock rise that shifts it
	assign rxClk = syncMaster ? serialClockOut ^ ~clockPolarity :
		serialClockIn;

	utx_transmitter DUT (.sys_clk, .rst, .txEnableBit, .charSizeCode,
		.parityEnableBit, .parityOdd, .twoStopBits, .doubleSpeedBit,
		.syncMode, .syncMaster, .clockPolarity, .rateDivisor,
		.rateDivisorLowWrite, .dataWrite, .dataWriteByte, .txNinthBit,
		.dataWriteReady, .bufferEmptyFlag, .txCompleteFlag, .txCompleteClear,
		.txCompleteIrqAck, .bufferEmptyIrqEnable, .txCompleteIrqEnable,
		.globalIrqEnable, .bufferEmptyIrq, .txCompleteIrq, .txdOut, .txdOe,
		.serialClockIn, .serialClockOut, .serialClockOe);

	utx_line_rx RX (.sys_clk, .lineIn(line), .serialClockIn(rxClk), .syncMode,
		.parityEnableBit, .dataBits(nBits), .bitCycles, .rxWord, .rxParity,
		.rxStart, .rxStop, .frameCnt);

	// Clock
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Watchdog against a hang
	initial begin
		repeat (60000) @(posedge sys_clk);
		error_cnt++;
		give_verdict();
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Format, rate and enables; divisor written before enabling
	task automatic fmt(input logic [2:0] c, input logic p, d, s, input int v);
		@(posedge sys_clk);
		charSizeCode <= c;
		parityEnableBit <= p;
		parityOdd <= 1'($urandom);
		twoStopBits <= s;
		doubleSpeedBit <= d;
		rateDivisor <= 12'(v);
		rateDivisorLowWrite <= 1'b1;
		bufferEmptyIrqEnable <= 1'($urandom);
		txCompleteIrqEnable <= 1'($urandom);
		globalIrqEnable <= 1'($urandom);
		nBits <= (c == 3'h7) ? 4'h9 : 4'(c) + 4'h5;
		bitCycles <= 16'((v + 1) * (d ? 8 : 16));
		@(posedge sys_clk);
		rateDivisorLowWrite <= 1'b0;
		txEnableBit <= 1'b1;
	endtask

	// Ninth bit set a cycle ahead of the low byte
	task automatic put(input logic [8:0] d);
		@(posedge sys_clk);
		txNinthBit <= d[8];
		@(posedge sys_clk);
		dataWrite <= 1'b1;
		dataWriteByte <= d[7:0];
		expQ.push_back(int'(d) & ((1 << nBits) - 1));
		@(posedge sys_clk);
		dataWrite <= 1'b0;
		@(negedge sys_clk);
	endtask

	// Counts cycles while the line holds level v, up to a bound
	task automatic hold(input logic v, input int lim);
		n = 0;
		while (line === v && n < lim) begin
			@(negedge sys_clk);
			n++;
		end
	endtask

	task automatic wait_frame;
		k = 0;
		while (frameCnt <= done && k < 3000) begin
			@(negedge sys_clk);
			k++;
		end
		check(9'(k < 3000), 9'h001);
		done++;
		w = expQ.pop_front();
		check(rxWord, 9'(w));
		check(rxParity, parityEnableBit ? 9'(^w ^ parityOdd) : 9'h000);
		check({rxStart, rxStop}, 9'h001);
	endtask

	task automatic wait_done;
		k = 0;
		while (txCompleteFlag !== 1'b1 && k < 3000) begin
			@(negedge sys_clk);
			k++;
		end
		check(txCompleteFlag, 9'h001);
		check(txCompleteIrq, 9'(txCompleteIrqEnable & globalIrqEnable));
		check(bufferEmptyIrq, 9'(bufferEmptyIrqEnable & globalIrqEnable));
	endtask

	// Flag cleared by service or by a written one, before the next write
	task automatic clr(input logic viaAck);
		@(posedge sys_clk);
		txCompleteIrqAck <= viaAck;
		txCompleteClear <= ~viaAck;
		@(posedge sys_clk);
		txCompleteIrqAck <= 1'b0;
		txCompleteClear <= 1'b0;
		@(negedge sys_clk);
		check(txCompleteFlag, 9'h000);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		w = $urandom(32'h4EA6);
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		check({bufferEmptyFlag, txCompleteFlag, dataWriteReady}, 9'h005);
		// Empty flag is status only; the bench never writes it
		check({txdOe, line, serialClockOe, serialClockOut}, 9'h004);
		$display("test reset done");
		for (int t = 0; t < 15; t++) begin
			fmt(sizes[t % 5], 1'($urandom), 1'($urandom), 1'($urandom),
				$urandom_range(2, 0));
			put(9'($urandom));
			check(bufferEmptyFlag, 9'h000);
			hold(1'b1, 3000);
			check({txdOe, bufferEmptyFlag}, 9'h003);
			hold(1'b0, 3000);
			if (expQ[0] % 2 == 1) check(9'(n), 9'(bitCycles));
			wait_frame;
			check(txCompleteFlag, 9'h000);
			wait_done;
			clr(1'(t));
		end
		$display("test random formats done");
		fmt(3'h3, 1'b0, 1'b0, 1'b0, 0);
		put(9'h0A5);
		hold(1'b1, 3000);
		@(posedge sys_clk);
		dataWrite <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			dataWriteByte <= 8'(i * 51 + 17);
			if (i < 2) expQ.push_back(i * 51 + 17);
			@(posedge sys_clk);
		end
		dataWrite <= 1'b0;
		@(negedge sys_clk);
		check({dataWriteReady, bufferEmptyFlag}, 9'h000);
		wait_frame;
		hold(1'b1, 3000);
		check(9'(n <= bitCycles), 9'h001);
		wait_frame;
		check(txCompleteFlag, 9'h000);
		wait_frame;
		wait_done;
		clr(1'b1);
		hold(1'b1, 400);
		check(9'(n), 9'h190);
		$display("test back to back done");
		put(9'h05A);
		hold(1'b1, 3000);
		@(posedge sys_clk);
		txEnableBit <= 1'b0;
		wait_frame;
		check(txdOe, 9'h001);
		wait_done;
		repeat (2) @(negedge sys_clk);
		check({txdOe, line}, 9'h001);
		@(posedge sys_clk);
		txEnableBit <= 1'b1;
		syncMode <= 1'b1;
		clr(1'b0);
		$display("test disable done");
		put(9'h0C3);
		repeat (32) begin
			repeat (4) @(posedge sys_clk);
			serialClockIn <= ~serialClockIn;
		end
		check(serialClockOe, 9'h000);
		wait_frame;
		wait_done;
		clr(1'b0);
		$display("test sync slave done");
		@(posedge sys_clk);
		syncMaster <= 1'b1;
		clockPolarity <= 1'b1;
		fmt(3'h7, 1'b1, 1'b0, 1'b1, 2);
		put(9'($urandom));
		wait_frame;
		check(serialClockOe, 9'h001);
		wait_done;
		$display("test sync master done");
		give_verdict();
	end
endmodule
